// ---- inc/core_exec_map.svh ----
`ifndef CORE_EXEC_MAP_SVH
`define CORE_EXEC_MAP_SVH

// register byte offsets
`define OFS_INSTR       8'h00
`define OFS_ACC         8'h04
`define OFS_OPTION      8'h08
`define OFS_STATUS      8'h0C
`define OFS_PC          8'h10
`define OFS_STACK_HEAD  8'h14
`define OFS_CTRL        8'h18
`define OFS_WATCHDOG    8'h1C
`define OFS_FILE_PTR    8'h20
`define OFS_FILE_DATA   8'h24

// instruction word fields
`define INSTR_LIT_LSB   0
`define INSTR_LIT_MSB   7
`define INSTR_FADR_LSB  8
`define INSTR_FADR_MSB  12
`define INSTR_DEST_BIT  15
`define INSTR_OP_LSB    16
`define INSTR_OP_MSB    18

// status bit positions
`define ST_CARRY_BIT    0
`define ST_DCARRY_BIT   1
`define ST_ZERO_BIT     2
`define ST_SLEEP_BIT    3
`define ST_EXPIRY_BIT   4
`define ST_WAKE_BIT     7

// control / state bit positions
`define CTRL_BUSY_BIT   0
`define CTRL_SLEEP_BIT  1

// reset values
`define RST_ACC         8'h00
`define RST_OPTION      8'hFF
`define RST_PC          9'h1FF
`define RST_STACK_HEAD  9'h000
`define RST_INSTR       32'h0000_0000
`define RST_WATCHDOG    8'h00
`define RST_WD_PRESCALE 8'h00

`endif

// ---- inc/core_exec_pkg.sv ----
package core_exec_pkg;

  typedef enum logic [2:0] {
    idle_op                   = 3'b000,
    literal_load_op           = 3'b001,
    option_load_op            = 3'b010,
    return_literal_op         = 3'b011,
    sleep_op                  = 3'b100,
    rotate_left_op            = 3'b101,
    rotate_right_op           = 3'b110,
    subtract_acc_from_file_op = 3'b111
  } op_e;

  typedef enum logic [1:0] {
    st_ready = 2'b00,
    st_exec  = 2'b01,
    st_flush = 2'b10,
    st_sleep = 2'b11
  } core_state_e;

endpackage

// ---- src/exec_alu.sv ----
`timescale 1ns/1ps
`include "core_exec_map.svh"

module exec_alu
  import core_exec_pkg::*;
(
  // operation and operands
  input wire op_e op,
  input wire logic [7:0] file_val,
  input wire logic [7:0] acc,
  input wire logic carry_in,
  // result and flags
  output logic [7:0] result,
  output logic carry_out,
  output logic dcarry_out,
  output logic zero_out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // f + ~w + 1: carry out is the inverted borrow
  assign diff = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
  assign low_diff = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  always_comb begin
    result = file_val;
    carry_out = carry_in;
    dcarry_out = 1'b0;
    zero_out = 1'b0;
    case (op)
      rotate_left_op: begin
        result = {file_val[6:0], carry_in};
        carry_out = file_val[7];
      end
      rotate_right_op: begin
        result = {carry_in, file_val[7:1]};
        carry_out = file_val[0];
      end
      subtract_acc_from_file_op: begin
        result = diff[7:0];
        carry_out = diff[8];
        dcarry_out = low_diff[4];
        zero_out = (diff[7:0] == 8'h00);
      end
      default: begin
        result = file_val;
      end
    endcase
  end

endmodule // exec_alu

// ---- src/core_exec.sv ----
// Operation
// - literal load copies the 8-bit immediate into the accumulator, flags untouched
// - option load copies the accumulator into the option register, flags untouched
// - return-literal loads immediate into accumulator and program counter from stack head
// - return-literal takes two cycles, the prefetched word being discarded
// - sleep clears the watchdog counter and its prescaler
// - sleep sets expiry flag, clears sleep-entry flag, keeps pin-change wake flag
// - on the same edge as the sleep flag update the core halts and stops its oscillator
// - rotate left through carry: carry into bit 0, bit 7 into carry
// - rotate right through carry: carry into bit 7, bit 0 into carry
// - subtract computes file minus accumulator, updating carry, digit carry, zero
// - destination bit 0 writes accumulator, 1 writes the addressed file register
`timescale 1ns/1ps
`include "core_exec_map.svh"

module core_exec
  import core_exec_pkg::*;
#(
  parameter int FILE_DEPTH = 32,
  parameter int PC_W = 9,
  parameter int WD_W = 8,
  parameter int WD_PRE_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core state
  output logic busy,
  output logic sleeping,
  output logic osc_run
);

  core_state_e state;
  logic [31:0] instr;
  logic [7:0] acc;
  logic [7:0] option_reg;
  logic flag_carry;
  logic flag_dcarry;
  logic flag_zero;
  logic sleep_entry_flag;
  logic watchdog_expiry_flag;
  logic pin_change_wake_flag;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack_head;
  logic [WD_W-1:0] watchdog_counter;
  logic [WD_PRE_W-1:0] wd_prescale;
  logic [4:0] file_ptr;
  logic [7:0] file_mem [FILE_DEPTH];

  // decoded instruction
  op_e op;
  logic [7:0] literal;
  logic [4:0] file_adr;
  logic dest_file;
  logic exec;
  logic [7:0] file_val;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_dcarry;
  logic alu_zero;
  logic alu_op;

  // bus decode
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [7:0] status_val;

  assign op = op_e'(instr[`INSTR_OP_MSB:`INSTR_OP_LSB]);
  assign literal = instr[`INSTR_LIT_MSB:`INSTR_LIT_LSB];
  assign file_adr = instr[`INSTR_FADR_MSB:`INSTR_FADR_LSB];
  assign dest_file = instr[`INSTR_DEST_BIT];
  assign exec = (state == st_exec);
  assign file_val = file_mem[file_adr];
  assign alu_op = (op == rotate_left_op) || (op == rotate_right_op) ||
                  (op == subtract_acc_from_file_op);

  assign apb_setup = psel & ~penable;
  // writes land only at the access edge that carries pready
  assign apb_wr = psel & penable & pready & pwrite;

  exec_alu u_alu (
    .op(op),
    .file_val(file_val),
    .acc(acc),
    .carry_in(flag_carry),
    .result(alu_result),
    .carry_out(alu_carry),
    .dcarry_out(alu_dcarry),
    .zero_out(alu_zero)
  );

  always_comb begin
    status_val = 8'h00;
    status_val[`ST_CARRY_BIT] = flag_carry;
    status_val[`ST_DCARRY_BIT] = flag_dcarry;
    status_val[`ST_ZERO_BIT] = flag_zero;
    status_val[`ST_SLEEP_BIT] = sleep_entry_flag;
    status_val[`ST_EXPIRY_BIT] = watchdog_expiry_flag;
    status_val[`ST_WAKE_BIT] = pin_change_wake_flag;
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `OFS_INSTR: rd_val = instr;
      `OFS_ACC: rd_val[7:0] = acc;
      `OFS_OPTION: rd_val[7:0] = option_reg;
      `OFS_STATUS: rd_val[7:0] = status_val;
      `OFS_PC: rd_val[PC_W-1:0] = pc;
      `OFS_STACK_HEAD: rd_val[PC_W-1:0] = stack_head;
      `OFS_CTRL: begin
        rd_val[`CTRL_BUSY_BIT] = (state != st_ready);
        rd_val[`CTRL_SLEEP_BIT] = (state == st_sleep);
      end
      `OFS_WATCHDOG: rd_val[WD_PRE_W+WD_W-1:0] = {wd_prescale, watchdog_counter};
      `OFS_FILE_PTR: rd_val[4:0] = file_ptr;
      `OFS_FILE_DATA: rd_val[7:0] = file_mem[file_ptr];
      default: rd_hit = 1'b0;
    endcase
  end

  // read data sampled in setup, so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~rd_hit;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_ready;
    end else begin
      case (state)
        st_ready: begin
          if (apb_wr && paddr == `OFS_INSTR) begin
            state <= st_exec;
          end
        end
        st_exec: begin
          if (op == return_literal_op) begin
            state <= st_flush;
          end else if (op == sleep_op) begin
            state <= st_sleep;
          end else begin
            state <= st_ready;
          end
        end
        st_flush: state <= st_ready;
        st_sleep: begin
          if (apb_wr && paddr == `OFS_CTRL && pwdata[`CTRL_SLEEP_BIT]) begin
            state <= st_ready;
          end
        end
        default: state <= st_ready;
      endcase
    end
  end

  // instruction writes while busy or asleep are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= `RST_INSTR;
    end else if (apb_wr && paddr == `OFS_INSTR && state == st_ready) begin
      instr <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      sleeping <= 1'b0;
      osc_run <= 1'b1;
    end else begin
      busy <= (state == st_ready) ? (apb_wr && paddr == `OFS_INSTR) :
              (state == st_exec) ? (op == return_literal_op) : 1'b0;
      if (exec && op == sleep_op) begin
        sleeping <= 1'b1;
        osc_run <= 1'b0;
      end else if (state == st_sleep && apb_wr && paddr == `OFS_CTRL &&
                   pwdata[`CTRL_SLEEP_BIT]) begin
        sleeping <= 1'b0;
        osc_run <= 1'b1;
      end
    end
  end

  // accumulator: execution outranks a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `RST_ACC;
    end else if (exec && (op == literal_load_op || op == return_literal_op)) begin
      acc <= literal;
    end else if (exec && alu_op && !dest_file) begin
      acc <= alu_result;
    end else if (apb_wr && paddr == `OFS_ACC) begin
      acc <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg <= `RST_OPTION;
    end else if (exec && op == option_load_op) begin
      option_reg <= acc;
    end
  end

  // arithmetic flags; of the ops only the alu ops touch them, and a bus write to the status register loads them too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_carry <= 1'b0;
      flag_dcarry <= 1'b0;
      flag_zero <= 1'b0;
    end else if (exec && alu_op) begin
      flag_carry <= alu_carry;
      if (op == subtract_acc_from_file_op) begin
        flag_dcarry <= alu_dcarry;
        flag_zero <= alu_zero;
      end
    end else if (apb_wr && paddr == `OFS_STATUS) begin
      flag_carry <= pwdata[`ST_CARRY_BIT];
      flag_dcarry <= pwdata[`ST_DCARRY_BIT];
      flag_zero <= pwdata[`ST_ZERO_BIT];
    end
  end

  // power flags start as after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_expiry_flag <= 1'b1;
      sleep_entry_flag <= 1'b1;
    end else if (exec && op == sleep_op) begin
      watchdog_expiry_flag <= 1'b1;
      sleep_entry_flag <= 1'b0;
    end
  end

  // wake flag is software owned here; sleep leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_wake_flag <= 1'b0;
    end else if (apb_wr && paddr == `OFS_STATUS) begin
      pin_change_wake_flag <= pwdata[`ST_WAKE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= `RST_PC;
    end else if (exec && op == return_literal_op) begin
      pc <= stack_head;
    end else if (exec) begin
      pc <= pc + PC_W'(1);
    end else if (apb_wr && paddr == `OFS_PC) begin
      pc <= pwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_head <= `RST_STACK_HEAD;
    end else if (apb_wr && paddr == `OFS_STACK_HEAD) begin
      stack_head <= pwdata[PC_W-1:0];
    end
  end

  // free running between sleeps; expiry handling lives elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter <= `RST_WATCHDOG;
      wd_prescale <= `RST_WD_PRESCALE;
    end else if (exec && op == sleep_op) begin
      watchdog_counter <= `RST_WATCHDOG;
      wd_prescale <= `RST_WD_PRESCALE;
    end else begin
      wd_prescale <= wd_prescale + WD_PRE_W'(1);
      if (&wd_prescale) begin
        watchdog_counter <= watchdog_counter + WD_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_ptr <= 5'h00;
    end else if (apb_wr && paddr == `OFS_FILE_PTR) begin
      file_ptr <= pwdata[4:0];
    end
  end

  // file registers: execution outranks a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else if (exec && alu_op && dest_file) begin
      file_mem[file_adr] <= alu_result;
    end else if (apb_wr && paddr == `OFS_FILE_DATA) begin
      file_mem[file_ptr] <= pwdata[7:0];
    end
  end

endmodule // core_exec

// ---- testbench/core_exec_asserts.sv ----
`timescale 1ns/1ps
module core_exec_asserts (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core state
  input wire logic busy,
  input wire logic sleeping,
  input wire logic osc_run
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire acc_wr = psel && penable && pready && pwrite;
  wire ex = acc_wr && paddr == 8'h00 && !busy && !sleeping;
  wire [2:0] op = pwdata[18:16];
  property p_ready_after_setup; setup |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  property p_no_stray_ready; !setup |=> !pready; endproperty
  a_no_stray_ready: assert property (p_no_stray_ready)
    else $error("ready without setup");
  property p_unmapped_err; setup && paddr > 8'h24 |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");
  property p_rdata_quiet; !pready |-> prdata == 32'h0; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside access");
  property p_idle_one; ex && op == 3'h0 |=> busy ##1 !busy; endproperty
  a_idle_one: assert property (p_idle_one)
    else $error("idle op not one cycle");
  property p_return_literal_two; ex && op == 3'h3 |=> busy [*2] ##1 !busy; endproperty
  a_return_literal_two: assert property (p_return_literal_two)
    else $error("return literal not two cycles");
  property p_sleep_enter; ex && op == 3'h4 |=> ##1 (sleeping && !osc_run); endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep not entered");
  property p_osc_inverse; osc_run != sleeping; endproperty
  a_osc_inverse: assert property (p_osc_inverse)
    else $error("oscillator runs in sleep");
  property p_sleep_holds;
    sleeping && !(acc_wr && paddr == 8'h18 && pwdata[1]) |=> sleeping;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("left sleep without wake");
  c_return_literal: cover property (ex && op == 3'h3);
  c_sleep: cover property (ex && op == 3'h4);
  c_unmapped: cover property (setup && paddr > 8'h24);
endmodule // core_exec_asserts

bind core_exec core_exec_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy), .sleeping(sleeping), .osc_run(osc_run));

// ---- testbench/mcu_instruction_subset_exec_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mcu_instruction_subset_exec_bench
  import core_exec_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, busy, sleeping, osc_run, e;
  int n_fail = 0, total_checks = 0, cyc = 0;
  core_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .sleeping(sleeping), .osc_run(osc_run));
  initial forever #5 pclk = ~pclk;
  // hang guard, well above the roughly 800 cycles used
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // idle cycle after each transfer keeps strobes single-driven per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  // instruction writes are dropped while busy, so let it finish
  task automatic ex(input op_e op, input logic d, input logic [4:0] f, input logic [7:0] k);
    apb(1'b1, 8'h00, {13'h0, op, d, 2'b00, f, k});
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'hFF);
    rd(8'h10, 32'h1FF);
    rd(8'h0C, 32'h18);
    rd(8'h28, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, 8'h08, 32'h11);
    rd(8'h08, 32'hFF);
    ex(literal_load_op, 1'b0, 5'h0, 8'hFF);
    rd(8'h04, 32'hFF);
    rd(8'h0C, 32'h18);
    ex(literal_load_op, 1'b0, 5'h0, 8'h5A);
    ex(option_load_op, 1'b0, 5'h0, 8'h00);
    rd(8'h08, 32'h5A);
    rd(8'h0C, 32'h18);
    apb(1'b1, 8'h14, 32'h123);
    // control read right after the write still sees the discarded fetch
    apb(1'b1, 8'h00, {13'h0, return_literal_op, 1'b0, 2'b00, 5'h0, 8'hA5});
    rd(8'h18, 32'h1);
    rd(8'h04, 32'hA5);
    rd(8'h10, 32'h123);
    apb(1'b1, 8'h10, 32'h0AA);
    apb(1'b1, 8'h00, {13'h0, idle_op, 1'b0, 2'b00, 5'h0, 8'h00});
    rd(8'h18, 32'h0);
    rd(8'h10, 32'h0AB);
    rd(8'h04, 32'hA5);
    rd(8'h0C, 32'h18);
    apb(1'b1, 8'h20, 32'h1F);
    apb(1'b1, 8'h24, 32'h81);
    ex(rotate_left_op, 1'b1, 5'h1F, 8'h00);
    rd(8'h24, 32'h02);
    rd(8'h04, 32'hA5);
    rd(8'h0C, 32'h19);
    ex(rotate_right_op, 1'b0, 5'h1F, 8'h00);
    rd(8'h04, 32'h81);
    rd(8'h24, 32'h02);
    rd(8'h0C, 32'h18);
    ex(literal_load_op, 1'b0, 5'h0, 8'h01);
    apb(1'b1, 8'h24, 32'h10);
    ex(subtract_acc_from_file_op, 1'b1, 5'h1F, 8'h00);
    rd(8'h24, 32'h0F);
    rd(8'h0C, 32'h19);
    ex(literal_load_op, 1'b0, 5'h0, 8'h0F);
    ex(subtract_acc_from_file_op, 1'b0, 5'h1F, 8'h00);
    rd(8'h04, 32'h00);
    rd(8'h0C, 32'h1F);
    // let the watchdog count up so clearing it shows
    apb(1'b1, 8'h0C, 32'h80);
    repeat (600) @(posedge pclk);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(q[7:0] != 8'h00, 1'b1)
    ex(sleep_op, 1'b0, 5'h0, 8'h00);
    `CHK(sleeping, 1'b1)
    `CHK(osc_run, 1'b0)
    rd(8'h0C, 32'h90);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(q[7:0], 8'h00)
    `CHK(q[15:8] < 8'h08, 1'b1)
    ex(literal_load_op, 1'b0, 5'h0, 8'h77);
    rd(8'h04, 32'h00);
    apb(1'b1, 8'h18, 32'h2);
    @(posedge pclk);
    `CHK(sleeping, 1'b0)
    `CHK(osc_run, 1'b1)
    end_of_test();
  end
endmodule // mcu_instruction_subset_exec_bench
